// ==== rtl/bias_cfg_pkg.sv ====
// constants for the panel bias voltage configuration registers
`default_nettype none
package bias_cfg_pkg;
  localparam logic [7:0] CMD_PAGE = 8'h04;
  localparam logic [7:0] ADDR_PWR_CTRL3 = 8'h6F;
  localparam logic [7:0] ADDR_COM_OUT = 8'h8B;
  localparam logic [7:0] ADDR_NEG_REG = 8'h8C;
  localparam logic [7:0] ADDR_CLAMP = 8'h8D;
  localparam logic [7:0] RST_PWR_CTRL3 = 8'h34;
  localparam logic [7:0] RST_COM_OUT = 8'hE3;
  localparam logic [7:0] RST_NEG_REG = 8'h03;
  localparam logic [7:0] RST_CLAMP = 8'h14;
  localparam logic [7:0] MASK_PWR_CTRL3 = 8'hFF;
  localparam logic [7:0] MASK_COM_OUT = 8'h08;
  localparam logic [7:0] MASK_LEVEL = 8'h7F;
  localparam int SRC_SEL_BIT = 0;
  localparam int MODE_SEL_BIT = 3;
  localparam logic [6:0] LEVEL_CODE_MIN = 7'h03;
  localparam logic [6:0] LEVEL_CODE_MAX = 7'h41;
  localparam int LEVEL_W = 9;
endpackage // bias_cfg_pkg
`default_nettype wire

// ==== rtl/cfg_byte_reg.sv ====
// one command register byte with fixed bits and reset value
`timescale 1ns/100ps
`default_nettype none
module cfg_byte_reg #(
  parameter logic [7:0] ADDR = 8'h00,
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic soft_rst_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic hit_o,
  output logic [7:0] q_o
);
  logic [7:0] val_ff;
  logic [7:0] nxt_val;
  assign hit_o = (addr_i == ADDR);
  // fixed bits always come from the reset value
  assign nxt_val = soft_rst_i ? RST :
                   (wr_i && hit_o) ? ((wdata_i & WMASK) | (RST & ~WMASK)) : val_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_ff <= RST;
    end else begin
      val_ff <= nxt_val;
    end
  end
  assign q_o = val_ff;
endmodule // cfg_byte_reg
`default_nettype wire

// ==== rtl/panel_bias_voltage_config_regs.sv ====
// command page 4 bias voltage configuration registers
`timescale 1ns/100ps
`default_nettype none
module panel_bias_voltage_config_regs (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic soft_rst_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic panel_orientation_bit_i,
  input wire logic [bias_cfg_pkg::LEVEL_W-1:0] first_common_level_i,
  input wire logic [bias_cfg_pkg::LEVEL_W-1:0] second_common_level_i,
  output logic [7:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic neg_logic_supply_src_sel_o,
  output logic common_output_mode_sel_o,
  output logic common_force_zero_o,
  output logic [bias_cfg_pkg::LEVEL_W-1:0] common_level_o,
  output logic [6:0] neg_gate_reg_level_code_o,
  output logic [6:0] gate_clamp_level_code_o,
  output logic neg_gate_level_valid_o,
  output logic gate_clamp_level_valid_o
);
  import bias_cfg_pkg::*;

  // ****************************************
  // reset synchroniser
  // ****************************************
  logic rst_s1_ff;
  logic rst_n_ff;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  // no power state gating: registers stay reachable in idle and sleep
  logic page_ok;
  logic wr_en;
  logic hit_pc3;
  logic hit_com;
  logic hit_neg;
  logic hit_clp;
  logic [7:0] q_pc3;
  logic [7:0] q_com;
  logic [7:0] q_neg;
  logic [7:0] q_clp;
  assign page_ok = (cmd_page_i == CMD_PAGE);
  assign wr_en = cmd_wr_i & page_ok;

  cfg_byte_reg #(
    .ADDR(ADDR_PWR_CTRL3),
    .RST(RST_PWR_CTRL3),
    .WMASK(MASK_PWR_CTRL3)
  ) u_pc3 (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .soft_rst_i(soft_rst_i),
    .wr_i(wr_en),
    .addr_i(cmd_addr_i),
    .wdata_i(cmd_wdata_i),
    .hit_o(hit_pc3),
    .q_o(q_pc3)
  );

  cfg_byte_reg #(
    .ADDR(ADDR_COM_OUT),
    .RST(RST_COM_OUT),
    .WMASK(MASK_COM_OUT)
  ) u_com (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .soft_rst_i(soft_rst_i),
    .wr_i(wr_en),
    .addr_i(cmd_addr_i),
    .wdata_i(cmd_wdata_i),
    .hit_o(hit_com),
    .q_o(q_com)
  );

  cfg_byte_reg #(
    .ADDR(ADDR_NEG_REG),
    .RST(RST_NEG_REG),
    .WMASK(MASK_LEVEL)
  ) u_neg (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .soft_rst_i(soft_rst_i),
    .wr_i(wr_en),
    .addr_i(cmd_addr_i),
    .wdata_i(cmd_wdata_i),
    .hit_o(hit_neg),
    .q_o(q_neg)
  );

  cfg_byte_reg #(
    .ADDR(ADDR_CLAMP),
    .RST(RST_CLAMP),
    .WMASK(MASK_LEVEL)
  ) u_clp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_ff),
    .soft_rst_i(soft_rst_i),
    .wr_i(wr_en),
    .addr_i(cmd_addr_i),
    .wdata_i(cmd_wdata_i),
    .hit_o(hit_clp),
    .q_o(q_clp)
  );

  // ****************************************
  // read path
  // ****************************************
  logic [7:0] rd_mux;
  assign rd_mux = hit_pc3 ? q_pc3 : hit_com ? q_com : hit_neg ? q_neg :
                  hit_clp ? q_clp : 8'h00;

  // ****************************************
  // derived outputs
  // ****************************************
  logic mode_sel;
  logic [LEVEL_W-1:0] level_pick;
  logic neg_ok;
  logic clp_ok;
  assign mode_sel = q_com[MODE_SEL_BIT];
  // orientation comes in from the panel operation register
  assign level_pick = mode_sel ? '0 :
                      (panel_orientation_bit_i ? second_common_level_i
                                               : first_common_level_i);
  // reserved codes are kept but flagged; host must avoid them
  assign neg_ok = (q_neg[6:0] >= LEVEL_CODE_MIN) && (q_neg[6:0] <= LEVEL_CODE_MAX);
  assign clp_ok = (q_clp[6:0] >= LEVEL_CODE_MIN) && (q_clp[6:0] <= LEVEL_CODE_MAX);

  // ****************************************
  // read answer
  // ****************************************
  // unmapped page-4 addresses answer 00h so the host never waits on them
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic rd_hit;
  assign rd_hit = cmd_rd_i & page_ok;
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= rd_hit ? rd_mux : 8'h00;
      rvalid_ff <= rd_hit;
    end
  end

  // ****************************************
  // supply source select
  // ****************************************
  logic src_ff;
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      src_ff <= RST_PWR_CTRL3[SRC_SEL_BIT];
    end else begin
      src_ff <= q_pc3[SRC_SEL_BIT];
    end
  end

  // ****************************************
  // common output
  // ****************************************
  // mode and force flags are twin flops so each output keeps its own driver
  logic mode_ff;
  logic zero_ff;
  logic [LEVEL_W-1:0] level_ff;
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_ff <= RST_COM_OUT[MODE_SEL_BIT];
      zero_ff <= RST_COM_OUT[MODE_SEL_BIT];
      level_ff <= '0;
    end else begin
      mode_ff <= mode_sel;
      zero_ff <= mode_sel;
      level_ff <= level_pick;
    end
  end

  // ****************************************
  // level codes
  // ****************************************
  logic [6:0] neg_ff;
  logic [6:0] clp_ff;
  logic neg_ok_ff;
  logic clp_ok_ff;
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      neg_ff <= RST_NEG_REG[6:0];
      clp_ff <= RST_CLAMP[6:0];
      neg_ok_ff <= 1'b1;
      clp_ok_ff <= 1'b1;
    end else begin
      neg_ff <= q_neg[6:0];
      clp_ff <= q_clp[6:0];
      neg_ok_ff <= neg_ok;
      clp_ok_ff <= clp_ok;
    end
  end

  assign cmd_rdata_o = rdata_ff;
  assign cmd_rvalid_o = rvalid_ff;
  assign neg_logic_supply_src_sel_o = src_ff;
  assign common_output_mode_sel_o = mode_ff;
  assign common_force_zero_o = zero_ff;
  assign common_level_o = level_ff;
  assign neg_gate_reg_level_code_o = neg_ff;
  assign gate_clamp_level_code_o = clp_ff;
  assign neg_gate_level_valid_o = neg_ok_ff;
  assign gate_clamp_level_valid_o = clp_ok_ff;
endmodule // panel_bias_voltage_config_regs
`default_nettype wire

// ==== test/bias_cfg_chk.sv ====
// port assertions for the bias configuration registers
`timescale 1ns/100ps
`default_nettype none
module bias_cfg_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_rdata_o,
  input wire logic cmd_rvalid_o,
  input wire logic common_force_zero_o,
  input wire logic [bias_cfg_pkg::LEVEL_W-1:0] common_level_o,
  input wire logic [6:0] neg_gate_reg_level_code_o,
  input wire logic [6:0] gate_clamp_level_code_o,
  input wire logic neg_gate_level_valid_o,
  input wire logic gate_clamp_level_valid_o
);
  import bias_cfg_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic rd4 = cmd_rd_i && cmd_page_i == CMD_PAGE;
  chk_read_answer: assert property (rd4 |=> cmd_rvalid_o)
    else $error("read not answered");
  chk_no_stray: assert property (!rd4 |=> !cmd_rvalid_o)
    else $error("stray read answer");
  chk_idle_rdata: assert property (!cmd_rvalid_o |-> cmd_rdata_o == 8'h00)
    else $error("read data not idle");
  chk_com_fixed: assert property (rd4 && cmd_addr_i == ADDR_COM_OUT
    |=> (cmd_rdata_o & 8'hF7) == 8'hE3) else $error("fixed bits moved");
  chk_level_bit7: assert property (rd4 && cmd_addr_i[7:1] == 7'h46
    |=> !cmd_rdata_o[7]) else $error("level bit 7 set");
  chk_forced_zero: assert property (common_force_zero_o |-> common_level_o == '0)
    else $error("forced level not zero");
  chk_neg_range: assert property ($stable(neg_gate_reg_level_code_o) [*2]
    |-> neg_gate_level_valid_o == (neg_gate_reg_level_code_o inside {[7'h03:7'h41]}))
    else $error("regulator range flag wrong");
  chk_clamp_range: assert property ($stable(gate_clamp_level_code_o) [*2]
    |-> gate_clamp_level_valid_o == (gate_clamp_level_code_o inside {[7'h03:7'h41]}))
    else $error("clamp range flag wrong");
endmodule // bias_cfg_chk
`default_nettype wire

// ==== test/host_cmd_model.sv ====
// host model issuing page-addressed command bytes
`timescale 1ns/100ps
`default_nettype none
module host_cmd_model (
  input wire logic clk_i,
  output logic [7:0] page_o,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] data_o
);
  initial {page_o, addr_o, wr_o, rd_o, data_o} = '0;
  // one strobe per byte; bytes sent as given, fixed-bit writes only on request
  task automatic xfer(input logic w, input logic [7:0] p, a, d);
    @(posedge clk_i);
    {page_o, addr_o, data_o, wr_o, rd_o} <= {p, a, d, w, !w};
    @(posedge clk_i);
    {wr_o, rd_o} <= 2'b00;
    data_o <= ~d; // released bus shows no stale byte
  endtask
endmodule // host_cmd_model
`default_nettype wire

// ==== test/panel_bias_voltage_config_regs_tb_top.sv ====
// self-checking bench for the bias configuration registers
`timescale 1ns/100ps
`default_nettype none
module panel_bias_voltage_config_regs_tb_top;
  import bias_cfg_pkg::*;
  logic clk_i = 0, arst_n_i = 0, soft_rst_i = 0, orient = 0, wr, rd, rv, src, fz, nv, cv, ms;
  logic [8:0] lvl1 = '0, lvl2 = '0, lvl;
  logic [7:0] pg, ad, wd, rdata, d;
  logic [6:0] nc, cc;
  logic [7:0] q[$];
  logic [7:0] ad_tbl[4] = '{8'h6F, 8'h8B, 8'h8C, 8'h8D};
  logic [7:0] rv_tbl[4] = '{8'h34, 8'hE3, 8'h03, 8'h14};
  logic [7:0] codes[3] = '{8'hC1, 8'h42, 8'h02};
  int fail_count = 0, tests_run = 0, seed = 80, i, k;
  always #5 clk_i = ~clk_i;
  host_cmd_model host_u (.clk_i, .page_o(pg), .addr_o(ad), .wr_o(wr), .rd_o(rd), .data_o(wd));
  panel_bias_voltage_config_regs dut_u (.clk_i, .arst_n_i, .soft_rst_i, .cmd_page_i(pg),
    .cmd_addr_i(ad), .cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_wdata_i(wd),
    .panel_orientation_bit_i(orient), .first_common_level_i(lvl1),
    .second_common_level_i(lvl2), .cmd_rdata_o(rdata), .cmd_rvalid_o(rv),
    .neg_logic_supply_src_sel_o(src), .common_output_mode_sel_o(ms), .common_force_zero_o(fz),
    .common_level_o(lvl), .neg_gate_reg_level_code_o(nc), .gate_clamp_level_code_o(cc),
    .neg_gate_level_valid_o(nv), .gate_clamp_level_valid_o(cv));
  task automatic chk(input string n, input logic [8:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] a, e);
    q.push_back(e);
    host_u.xfer(0, CMD_PAGE, a, 8'h00);
  endtask
  task automatic st;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fin(input string n);
    for (i = 0; i < 9 && q.size() > 0; i++) @(negedge clk_i);
    if (q.size() > 0) begin
      fail_count++;
      close_out();
    end else $display("test %s done", n);
  endtask
  always @(negedge clk_i) if (rv === 1'b1) begin
    if (q.size() == 0) begin
      fail_count++;
      $display("MISMATCH rdata expected none seen %h", rdata);
    end else chk("rdata", q.pop_front(), rdata);
  end
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1;
    repeat (3) @(posedge clk_i);
    for (k = 0; k < 4; k++) rdx(ad_tbl[k], rv_tbl[k]);
    chk("src_sel", 0, src);
    host_u.xfer(1, CMD_PAGE, ADDR_PWR_CTRL3, 8'h35);
    st;
    chk("src_sel", 1, src);
    fin("reset and source");
    @(posedge clk_i) {lvl1, lvl2} <= {9'($random(seed)) | 9'h001, 9'($random(seed))};
    host_u.xfer(1, CMD_PAGE, ADDR_COM_OUT, 8'hFF);
    st;
    chk("force", 1, fz);
    chk("mode_sel", 1, ms);
    chk("forced_level", 0, lvl);
    rdx(ADDR_COM_OUT, 8'hEB);
    host_u.xfer(1, CMD_PAGE, ADDR_COM_OUT, 8'h00);
    for (k = 0; k < 4; k++) begin
      @(posedge clk_i) {orient, lvl1, lvl2} <= {k[0], 9'($random(seed)), 9'($random(seed))};
      st;
      chk("level", k[0] ? lvl2 : lvl1, lvl);
      chk("mode_sel", 0, ms);
    end
    fin("common output");
    for (k = 0; k < 4; k++) begin
      d = k < 3 ? codes[k] : 8'($random(seed));
      host_u.xfer(1, CMD_PAGE, ADDR_NEG_REG, d);
      host_u.xfer(1, CMD_PAGE, ADDR_CLAMP, ~d);
      st;
      chk("neg_code", {2'b00, d[6:0]}, {2'b00, nc});
      chk("neg_valid", (d[6:0] inside {[7'h03:7'h41]}), nv);
      chk("clamp_code", {2'b00, ~d[6:0]}, {2'b00, cc});
      chk("clamp_valid", (~d[6:0] inside {[7'h03:7'h41]}), cv);
      rdx(ADDR_CLAMP, {1'b0, ~d[6:0]});
    end
    host_u.xfer(1, 8'h03, ADDR_NEG_REG, 8'h10);
    host_u.xfer(0, 8'h03, ADDR_NEG_REG, 8'h00);
    rdx(8'h8A, 8'h00);
    rdx(ADDR_NEG_REG, {1'b0, d[6:0]});
    fin("levels and refusals");
    @(posedge clk_i) soft_rst_i <= 1;
    @(posedge clk_i) soft_rst_i <= 0;
    st;
    chk("src_sel", 0, src);
    chk("neg_code", 9'h003, {2'b00, nc});
    for (k = 0; k < 4; k++) rdx(ad_tbl[k], rv_tbl[k]);
    fin("soft reset");
    close_out();
  end
endmodule // panel_bias_voltage_config_regs_tb_top
bind panel_bias_voltage_config_regs bias_cfg_chk chk_u (.clk_i, .arst_n_i, .cmd_page_i,
  .cmd_addr_i, .cmd_rd_i, .cmd_rdata_o, .cmd_rvalid_o, .common_force_zero_o, .common_level_o,
  .neg_gate_reg_level_code_o, .gate_clamp_level_code_o, .neg_gate_level_valid_o,
  .gate_clamp_level_valid_o);
`default_nettype wire
